// ---- common/cmc_params.svh ----
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
// Register selects on the 32-bit register port (word index)
`define CMC_ADDR_IDENTITY 2'h0
`define CMC_ADDR_CONTROL 2'h1
// Identity fields (arbitrary neutral values)
`define CMC_PART_CODE 4'h1
`define CMC_SILICON_REV 4'h0
// Control register field positions
`define CMC_SPACING_HI 31
`define CMC_SPACING_LO 28
`define CMC_ABORT_BIT 27
`define CMC_REQ_HI 26
`define CMC_REQ_LO 24
`define CMC_CUR_HI 23
`define CMC_CUR_LO 21
`define CMC_QUEUE_BIT 20
`define CMC_LOG_BIT 19
`define CMC_FALLBACK_BIT 18
`define CMC_GATEWAY_BIT 17
`define CMC_RESEND_BIT 16
`define CMC_RATE_BIT 12
`define CMC_BUSY_BIT 11
`define CMC_WFT_HI 10
`define CMC_WFT_LO 9
`define CMC_WAKE_BIT 8
`define CMC_PXE_BIT 6
`define CMC_CRC_BIT 5
`define CMC_DATA_FILTER_BIT_COUNT_HI 4
`define CMC_DATA_FILTER_BIT_COUNT_LO 0
// Reset values
`define CMC_RST_SPACING 4'h0
`define CMC_RST_MODE 3'h4
`define CMC_RST_WFT 2'h3
`define CMC_DATA_FILTER_BIT_COUNT_MAX 5'h12
// Spacing codes
`define CMC_SPACING_NONE 4'h0
`define CMC_SPACING_CAP 4'hB
`define CMC_SPACING_MAXLOG 5'h0C
// Mode change settle time in clocks
`define CMC_MODE_SETTLE 4'h8
`endif

// ---- common/cmc_pkg.sv ----
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_MODE_NORMAL_FD = 3'h0,
      CMC_MODE_SLEEP = 3'h1,
      CMC_MODE_INT_LOOP = 3'h2,
      CMC_MODE_LISTEN = 3'h3,
      CMC_MODE_CONFIG = 3'h4,
      CMC_MODE_EXT_LOOP = 3'h5,
      CMC_MODE_NORMAL_20 = 3'h6,
      CMC_MODE_RESTRICT = 3'h7
   } cmc_mode_e;
   typedef enum logic [1:0] {
      CMC_ST_IDLE,
      CMC_ST_CHANGE,
      CMC_ST_ABORT
   } cmc_state_e;
endpackage

// ---- hdl/cmc_spacing.sv ----
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_spacing (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Control
   input wire logic [3:0] i_code,
   input wire logic i_send_done,
   input wire logic i_bit_tick,
   // Status
   output logic o_gap_busy
);
   logic [12:0] cnt_ff;
   logic [12:0] nxt_cnt;
   logic [4:0] log2_len;

   always_comb begin
      if (i_code == `CMC_SPACING_NONE) begin
         log2_len = 5'h00;
      end else if (i_code > `CMC_SPACING_CAP) begin
         log2_len = `CMC_SPACING_MAXLOG;
      end else begin
         log2_len = {1'b0, i_code};
      end
   end

   always_comb begin
      nxt_cnt = cnt_ff;
      if (i_send_done && (i_code != `CMC_SPACING_NONE)) begin
         nxt_cnt = 13'(13'h0001 << log2_len);
      end else if (i_bit_tick && (cnt_ff != 13'h0000)) begin
         nxt_cnt = cnt_ff - 13'h0001;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_ff <= 13'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_gap_busy = (cnt_ff != 13'h0000);
endmodule

// ---- hdl/cmc_top.sv ----
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_top
   import cmc_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [3:0] i_reg_be,
   output logic [31:0] o_reg_rdata,
   // Protocol engine status
   input wire logic i_sending,
   input wire logic i_receiving,
   input wire logic i_send_done,
   input wire logic i_bit_tick,
   input wire logic i_aborts_done,
   input wire logic i_mode_ack,
   input wire logic i_system_error,
   input wire logic i_error_passive,
   input wire logic i_msg_esi,
   input wire logic i_msg_brs,
   input wire logic i_bus_activity,
   input wire logic [7:0] i_wake_len_0,
   input wire logic [7:0] i_wake_len_1,
   input wire logic [7:0] i_wake_len_2,
   input wire logic [7:0] i_wake_len_3,
   // Controls to protocol engine
   output cmc_pkg::cmc_mode_e o_mode,
   output logic o_abort_req,
   output logic o_send_hold,
   output logic o_queue_on,
   output logic o_log_on,
   output logic o_resend_limited,
   output logic o_esi_tx,
   output logic o_brs_tx,
   output logic o_pxe_form_error,
   output logic o_crc_standard,
   output logic [4:0] o_data_filter_bits,
   output logic o_osc_off,
   output logic o_wake
);
   import cmc_pkg::*;

   logic [3:0] spacing_ff, nxt_spacing;
   logic abort_ff, nxt_abort;
   logic [2:0] req_ff, nxt_req;
   cmc_mode_e mode_ff, nxt_mode;
   cmc_mode_e target_ff, nxt_target;
   cmc_state_e st_ff, nxt_st;
   logic [3:0] settle_ff, nxt_settle;
   logic queue_ff, nxt_queue;
   logic log_ff, nxt_log;
   logic fallback_ff, nxt_fallback;
   logic gateway_ff, nxt_gateway;
   logic resend_ff, nxt_resend;
   logic rate_ff, nxt_rate;
   logic [1:0] wft_ff, nxt_wft;
   logic wake_ff, nxt_wake;
   logic pxe_ff, nxt_pxe;
   logic crc_ff, nxt_crc;
   logic [4:0] data_filter_bit_count_ff, nxt_data_filter_bit_count;
   logic [31:0] rdata_ff, nxt_rdata;
   logic ctl_wr;
   logic in_config;
   logic [31:0] ctl_word;
   logic [2:0] shown_mode;

   function automatic logic lane_hit(input logic [3:0] be, input int bitpos);
      lane_hit = be[bitpos / 8];
   endfunction

   assign ctl_wr = i_reg_wr && (i_reg_addr == `CMC_ADDR_CONTROL);
   assign in_config = (mode_ff == CMC_MODE_CONFIG);

   // Register writes
   always_comb begin
      nxt_spacing = spacing_ff;
      nxt_abort = abort_ff;
      nxt_req = req_ff;
      nxt_queue = queue_ff;
      nxt_log = log_ff;
      nxt_fallback = fallback_ff;
      nxt_gateway = gateway_ff;
      nxt_resend = resend_ff;
      nxt_rate = rate_ff;
      nxt_wft = wft_ff;
      nxt_wake = wake_ff;
      nxt_pxe = pxe_ff;
      nxt_crc = crc_ff;
      nxt_data_filter_bit_count = data_filter_bit_count_ff;
      if (ctl_wr && lane_hit(i_reg_be, `CMC_SPACING_LO)) begin
         nxt_spacing = i_reg_wdata[`CMC_SPACING_HI:`CMC_SPACING_LO];
         nxt_req = i_reg_wdata[`CMC_REQ_HI:`CMC_REQ_LO];
      end
      // Fallback becomes the request too, else the sequencer undoes it
      if (i_system_error && !in_config && (st_ff == CMC_ST_IDLE)) begin
         nxt_req = fallback_ff ? CMC_MODE_LISTEN : CMC_MODE_RESTRICT;
      end
      if (ctl_wr && lane_hit(i_reg_be, `CMC_RATE_BIT)) begin
         nxt_rate = i_reg_wdata[`CMC_RATE_BIT];
      end
      if (ctl_wr && in_config && lane_hit(i_reg_be, `CMC_QUEUE_BIT)) begin
         nxt_queue = i_reg_wdata[`CMC_QUEUE_BIT];
         nxt_log = i_reg_wdata[`CMC_LOG_BIT];
         nxt_fallback = i_reg_wdata[`CMC_FALLBACK_BIT];
         nxt_gateway = i_reg_wdata[`CMC_GATEWAY_BIT];
         nxt_resend = i_reg_wdata[`CMC_RESEND_BIT];
      end
      if (ctl_wr && in_config && lane_hit(i_reg_be, `CMC_WAKE_BIT)) begin
         nxt_wft = i_reg_wdata[`CMC_WFT_HI:`CMC_WFT_LO];
         nxt_wake = i_reg_wdata[`CMC_WAKE_BIT];
      end
      if (ctl_wr && lane_hit(i_reg_be, `CMC_DATA_FILTER_BIT_COUNT_LO)) begin
         if (in_config) begin
            nxt_pxe = i_reg_wdata[`CMC_PXE_BIT];
            nxt_crc = i_reg_wdata[`CMC_CRC_BIT];
         end
         nxt_data_filter_bit_count = i_reg_wdata[`CMC_DATA_FILTER_BIT_COUNT_HI:`CMC_DATA_FILTER_BIT_COUNT_LO];
      end
      // Device clears abort once done; a new set wins
      if (ctl_wr && lane_hit(i_reg_be, `CMC_ABORT_BIT) && i_reg_wdata[`CMC_ABORT_BIT]) begin
         nxt_abort = 1'b1;
      end else if (abort_ff && i_aborts_done) begin
         nxt_abort = 1'b0;
      end
   end

   // Mode transition sequencer
   always_comb begin
      nxt_mode = mode_ff;
      nxt_target = target_ff;
      nxt_st = st_ff;
      nxt_settle = settle_ff;
      case (st_ff)
         CMC_ST_IDLE: begin
            if (i_system_error && !in_config) begin
               nxt_target = fallback_ff ? CMC_MODE_LISTEN : CMC_MODE_RESTRICT;
               nxt_st = CMC_ST_CHANGE;
               nxt_settle = `CMC_MODE_SETTLE;
            end else if (req_ff != mode_ff) begin
               nxt_target = cmc_mode_e'(req_ff);
               nxt_st = CMC_ST_CHANGE;
               nxt_settle = `CMC_MODE_SETTLE;
            end
         end
         CMC_ST_CHANGE: begin
            if (settle_ff != 4'h0) begin
               nxt_settle = settle_ff - 4'h1;
            end else if (i_mode_ack && !i_sending && !i_receiving) begin
               nxt_mode = target_ff;
               nxt_st = CMC_ST_IDLE;
            end
         end
         default: nxt_st = CMC_ST_IDLE;
      endcase
   end

   assign shown_mode = (mode_ff == CMC_MODE_SLEEP) ? `CMC_RST_MODE : mode_ff;
   assign o_osc_off = (mode_ff == CMC_MODE_SLEEP);

   always_comb begin
      ctl_word = 32'h0000_0000;
      ctl_word[`CMC_SPACING_HI:`CMC_SPACING_LO] = spacing_ff;
      ctl_word[`CMC_ABORT_BIT] = abort_ff;
      ctl_word[`CMC_REQ_HI:`CMC_REQ_LO] = req_ff;
      ctl_word[`CMC_CUR_HI:`CMC_CUR_LO] = shown_mode;
      ctl_word[`CMC_QUEUE_BIT] = queue_ff;
      ctl_word[`CMC_LOG_BIT] = log_ff;
      ctl_word[`CMC_FALLBACK_BIT] = fallback_ff;
      ctl_word[`CMC_GATEWAY_BIT] = gateway_ff;
      ctl_word[`CMC_RESEND_BIT] = resend_ff;
      ctl_word[`CMC_RATE_BIT] = rate_ff;
      ctl_word[`CMC_BUSY_BIT] = i_sending || i_receiving;
      ctl_word[`CMC_WFT_HI:`CMC_WFT_LO] = wft_ff;
      ctl_word[`CMC_WAKE_BIT] = wake_ff;
      ctl_word[`CMC_PXE_BIT] = pxe_ff;
      ctl_word[`CMC_CRC_BIT] = crc_ff;
      ctl_word[`CMC_DATA_FILTER_BIT_COUNT_HI:`CMC_DATA_FILTER_BIT_COUNT_LO] = data_filter_bit_count_ff;
   end

   always_comb begin
      case (i_reg_addr)
         `CMC_ADDR_IDENTITY: nxt_rdata = {24'h000000, `CMC_PART_CODE, `CMC_SILICON_REV};
         `CMC_ADDR_CONTROL: nxt_rdata = ctl_word;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         spacing_ff <= `CMC_RST_SPACING;
         abort_ff <= 1'b0;
         req_ff <= `CMC_RST_MODE;
         mode_ff <= CMC_MODE_CONFIG;
         target_ff <= CMC_MODE_CONFIG;
         st_ff <= CMC_ST_IDLE;
         settle_ff <= 4'h0;
         queue_ff <= 1'b1;
         log_ff <= 1'b1;
         fallback_ff <= 1'b0;
         gateway_ff <= 1'b0;
         resend_ff <= 1'b0;
         rate_ff <= 1'b0;
         wft_ff <= `CMC_RST_WFT;
         wake_ff <= 1'b1;
         pxe_ff <= 1'b1;
         crc_ff <= 1'b1;
         data_filter_bit_count_ff <= 5'h00;
         rdata_ff <= 32'h0000_0000;
      end else begin
         spacing_ff <= nxt_spacing;
         abort_ff <= nxt_abort;
         req_ff <= nxt_req;
         mode_ff <= nxt_mode;
         target_ff <= nxt_target;
         st_ff <= nxt_st;
         settle_ff <= nxt_settle;
         queue_ff <= nxt_queue;
         log_ff <= nxt_log;
         fallback_ff <= nxt_fallback;
         gateway_ff <= nxt_gateway;
         resend_ff <= nxt_resend;
         rate_ff <= nxt_rate;
         wft_ff <= nxt_wft;
         wake_ff <= nxt_wake;
         pxe_ff <= nxt_pxe;
         crc_ff <= nxt_crc;
         data_filter_bit_count_ff <= nxt_data_filter_bit_count;
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_reg_rdata = rdata_ff;
   assign o_mode = mode_ff;
   assign o_abort_req = abort_ff;
   assign o_queue_on = queue_ff;
   assign o_log_on = log_ff;
   assign o_resend_limited = resend_ff;
   assign o_esi_tx = gateway_ff ? (i_msg_esi || i_error_passive) : i_error_passive;
   assign o_brs_tx = i_msg_brs && !rate_ff;
   assign o_pxe_form_error = pxe_ff;
   assign o_crc_standard = crc_ff;
   // Invalid counts clamp to 18 bits
   assign o_data_filter_bits = (data_filter_bit_count_ff > `CMC_DATA_FILTER_BIT_COUNT_MAX) ? `CMC_DATA_FILTER_BIT_COUNT_MAX : data_filter_bit_count_ff;

   cmc_spacing u_spacing (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_code(spacing_ff),
      .i_send_done(i_send_done),
      .i_bit_tick(i_bit_tick),
      .o_gap_busy(o_send_hold)
   );

   cmc_wake_filter u_wake (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_enable(wake_ff),
      .i_time_sel(wft_ff),
      .i_len_0(i_wake_len_0),
      .i_len_1(i_wake_len_1),
      .i_len_2(i_wake_len_2),
      .i_len_3(i_wake_len_3),
      .i_activity(i_bus_activity && o_osc_off),
      .o_wake(o_wake)
   );
endmodule

// ---- hdl/cmc_wake_filter.sv ----
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_wake_filter (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_enable,
   input wire logic [1:0] i_time_sel,
   input wire logic [7:0] i_len_0,
   input wire logic [7:0] i_len_1,
   input wire logic [7:0] i_len_2,
   input wire logic [7:0] i_len_3,
   input wire logic i_activity,
   // Result
   output logic o_wake
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [7:0] limit;

   always_comb begin
      case (i_time_sel)
         2'h0: limit = i_len_0;
         2'h1: limit = i_len_1;
         2'h2: limit = i_len_2;
         default: limit = i_len_3;
      endcase
   end

   always_comb begin
      nxt_cnt = 8'h00;
      if (i_activity && (cnt_ff != 8'hFF)) begin
         nxt_cnt = cnt_ff + 8'h01;
      end else if (i_activity) begin
         nxt_cnt = cnt_ff;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_wake = i_enable ? (i_activity && (cnt_ff >= limit)) : i_activity;
endmodule

// ---- testbench/cmc_engine_model.sv ----
`timescale 1ns/1ps
module cmc_engine_model (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // From the block, and the slow select from the test
   input wire logic i_abort_req,
   input wire logic i_slow,
   // To the block
   output logic o_mode_ack,
   output logic o_aborts_done,
   output logic o_bit_tick
);
   logic [3:0] cnt_ff;
   logic [2:0] abt_ff;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_ff <= 4'h0;
         abt_ff <= 3'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
         abt_ff <= i_abort_req ? abt_ff + 3'h1 : 3'h0;
      end
   end
   // Ready once in sixteen when slow
   assign o_mode_ack = !i_slow || cnt_ff == 4'hF;
   assign o_aborts_done = abt_ff == 3'h5;
   // One bit per clock, so gaps stay short in simulation
   assign o_bit_tick = 1'b1;
endmodule

// ---- testbench/cmc_top_asserts.sv ----
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_top_asserts
   import cmc_pkg::*;
(
   // Clock, reset, register port
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [3:0] i_reg_be,
   input wire logic [31:0] o_reg_rdata,
   // Engine side
   input wire logic i_sending,
   input wire logic i_receiving,
   input wire logic i_aborts_done,
   input wire logic i_error_passive,
   input wire logic i_msg_esi,
   input wire logic i_msg_brs,
   input wire cmc_mode_e o_mode,
   input wire logic o_abort_req,
   input wire logic o_queue_on,
   input wire logic o_log_on,
   input wire logic o_esi_tx,
   input wire logic o_brs_tx,
   input wire logic [4:0] o_data_filter_bits,
   input wire logic o_wake
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic rate_ff;
   logic gw_ff;
   wire logic ctl_wr = i_reg_wr && i_reg_addr == `CMC_ADDR_CONTROL;
   // Shadows of bits that never reach a port of their own
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rate_ff <= 1'b0;
         gw_ff <= 1'b0;
      end else begin
         if (ctl_wr && i_reg_be[1]) begin
            rate_ff <= i_reg_wdata[`CMC_RATE_BIT];
         end
         if (ctl_wr && i_reg_be[2] && o_mode == CMC_MODE_CONFIG) begin
            gw_ff <= i_reg_wdata[`CMC_GATEWAY_BIT];
         end
      end
   end
   id_read_a: assert property (i_reg_addr == `CMC_ADDR_IDENTITY |=>
      o_reg_rdata == {24'h00_0000, `CMC_PART_CODE, `CMC_SILICON_REV})
      else $error("identity read wrong");
   busy_bit_a: assert property (i_reg_addr == `CMC_ADDR_CONTROL |=>
      o_reg_rdata[`CMC_BUSY_BIT] == $past(i_sending || i_receiving))
      else $error("busy bit wrong");
   sleep_status_a: assert property (o_mode == CMC_MODE_SLEEP && ctl_wr == 1'b0 &&
      i_reg_addr == `CMC_ADDR_CONTROL |=> o_reg_rdata[`CMC_CUR_HI:`CMC_CUR_LO] == 3'h4)
      else $error("sleep status not configuration");
   mode_settle_a: assert property (ctl_wr && i_reg_be[3] |=> $stable(o_mode) [*8])
      else $error("mode changed too early");
   abort_set_a: assert property (ctl_wr && i_reg_be[3] &&
      i_reg_wdata[`CMC_ABORT_BIT] |=> o_abort_req)
      else $error("abort not set");
   abort_hold_a: assert property (o_abort_req && !i_aborts_done |=> o_abort_req)
      else $error("abort dropped early");
   abort_clear_a: assert property (o_abort_req && i_aborts_done && !ctl_wr |=>
      !o_abort_req)
      else $error("abort not cleared");
   rate_block_a: assert property (o_brs_tx == (i_msg_brs && !rate_ff))
      else $error("rate switch wrong");
   esi_gate_a: assert property (o_esi_tx == (i_error_passive || (gw_ff && i_msg_esi)))
      else $error("error indicator wrong");
   cfg_lock_a: assert property (o_mode != CMC_MODE_CONFIG |=>
      $stable(o_queue_on) && $stable(o_log_on))
      else $error("config bit changed outside configuration");
   filter_clamp_a: assert property (o_data_filter_bits <= `CMC_DATA_FILTER_BIT_COUNT_MAX)
      else $error("filter count above limit");
   wake_sleep_a: assert property (o_wake |-> o_mode == CMC_MODE_SLEEP)
      else $error("wake outside sleep");
   cover property (o_mode == CMC_MODE_SLEEP);
   cover property (o_abort_req && i_aborts_done);
   cover property (o_wake);
endmodule

// ---- testbench/test_cmc_top.sv ----
`timescale 1ns/1ps
`include "cmc_params.svh"
module test_cmc_top;
   import cmc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic reg_wr = 1'b0, sending = 1'b0, receiving = 1'b0, send_done = 1'b0, sys_err = 1'b0;
   logic pas = 1'b0, esi = 1'b0, brs = 1'b0, act = 1'b0, slow = 1'b0;
   logic rd_go = 1'b0, rd_d = 1'b0;
   logic ack, ab_done, tick, abort_req, hold, osc_off, wake, brs_tx, q_on, l_on, r_lim, pxe, crc;
   logic [4:0] dfb;
   logic [31:0] rdata;
   cmc_mode_e mode;
   // Start value 66246
   logic [31:0] seed = 32'h0001_02C6;
   logic [63:0] exp_q[$];
   int fails = 0;
   int n_checks = 0;
   int codes[7] = '{0, 1, 2, 10, 11, 12, 15};
   int gaps[7] = '{0, 2, 4, 1024, 2048, 4096, 4096};
   cmc_top dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(reg_wr),
      .i_reg_wdata(wdata), .i_reg_be(be), .o_reg_rdata(rdata), .i_sending(sending),
      .i_receiving(receiving), .i_send_done(send_done), .i_bit_tick(tick),
      .i_aborts_done(ab_done), .i_mode_ack(ack), .i_system_error(sys_err),
      .i_error_passive(pas), .i_msg_esi(esi), .i_msg_brs(brs), .i_bus_activity(act),
      .i_wake_len_0(8'h03), .i_wake_len_1(8'h04), .i_wake_len_2(8'h05), .i_wake_len_3(8'h0A),
      .o_mode(mode), .o_abort_req(abort_req), .o_send_hold(hold), .o_queue_on(q_on),
      .o_log_on(l_on), .o_resend_limited(r_lim), .o_esi_tx(), .o_brs_tx(brs_tx),
      .o_pxe_form_error(pxe), .o_crc_standard(crc), .o_data_filter_bits(dfb),
      .o_osc_off(osc_off), .o_wake(wake));
   cmc_engine_model peer (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_abort_req(abort_req),
      .i_slow(slow), .o_mode_ack(ack), .o_aborts_done(ab_done), .o_bit_tick(tick));
   initial begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
   endfunction
   always @(posedge i_ref_clk) begin
      seed <= lfsr(seed);
      pas <= seed[0];
      esi <= seed[1];
      brs <= seed[2];
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Read data lands one edge after the address, checked here off the queue
   always @(posedge i_ref_clk) rd_d <= rd_go;
   always @(negedge i_ref_clk) begin
      if (rd_d) begin
         chk(rdata & exp_q[0][31:0], exp_q[0][63:32] & exp_q[0][31:0]);
         void'(exp_q.pop_front());
      end
   end
   task automatic rd(input logic [1:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({e, m});
      @(posedge i_ref_clk);
      addr <= a;
      rd_go <= 1'b1;
      @(posedge i_ref_clk);
      rd_go <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] b, input logic [31:0] d);
      @(posedge i_ref_clk);
      addr <= `CMC_ADDR_CONTROL;
      reg_wr <= 1'b1;
      be <= b;
      wdata <= d;
      @(posedge i_ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Waits for both the status field and the mode output, so no request overlaps a change
   task automatic poll(input cmc_mode_e m);
      logic [2:0] s;
      int i;
      s = (m == CMC_MODE_SLEEP) ? 3'h4 : m;
      i = 0;
      @(posedge i_ref_clk);
      addr <= `CMC_ADDR_CONTROL;
      repeat (2) @(negedge i_ref_clk);
      while ((rdata[23:21] !== s || mode !== m) && i < 200) begin
         @(negedge i_ref_clk);
         i++;
      end
      chk(32'({rdata[23:21], mode}), 32'({s, m}));
   endtask
   initial begin
      logic [31:0] d;
      int cnt;
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(`CMC_ADDR_CONTROL, 32'h0498_0760, 32'hFFFF_FFFF);
      rd(`CMC_ADDR_IDENTITY, {24'h0, `CMC_PART_CODE, `CMC_SILICON_REV}, 32'hFFFF_FFFF);
      rd(2'h3, 32'h0, 32'hFFFF_FFFF);
      @(negedge i_ref_clk);
      chk(32'({q_on, l_on, r_lim, pxe, crc}), 32'h1B);
      repeat (3) begin
         d = seed;
         wr(4'h5, d);
         @(negedge i_ref_clk);
         chk(32'({q_on, l_on, r_lim, pxe, crc}), 32'({d[20], d[19], d[16], d[6], d[5]}));
         chk(32'(dfb), 32'(d[4:0] > 5'h12 ? 5'h12 : d[4:0]));
      end
      rd(`CMC_ADDR_CONTROL, d & 32'h001F_007F, 32'h001F_00FF);
      // Filter time 01 so the sleep scenario sees a length other than the reset one
      wr(4'h2, 32'h0000_1300);
      for (int m = 0; m < 8; m++) begin
         slow <= m[0];
         wr(4'h8, 32'(m) << 24);
         poll(cmc_mode_e'(m));
         if (m == 1) begin
            chk(32'(osc_off), 32'h1);
            @(posedge i_ref_clk);
            act <= 1'b1;
            // Length 4: still quiet after three counted clocks, awake at the fourth
            repeat (4) @(negedge i_ref_clk);
            chk(32'(wake), 32'h0);
            @(negedge i_ref_clk);
            chk(32'(wake), 32'h1);
            @(posedge i_ref_clk);
            act <= 1'b0;
         end
         if (m == 0) begin
            wr(4'h4, 32'h0);
            @(negedge i_ref_clk);
            chk(32'({q_on, l_on}), 32'({d[20], d[19]}));
            @(posedge i_ref_clk);
            receiving <= 1'b1;
            rd(`CMC_ADDR_CONTROL, 32'h0000_0800, 32'h0000_0800);
            wr(4'h8, 32'h0800_0000);
            @(negedge i_ref_clk);
            chk(32'(abort_req), 32'h1);
            @(posedge i_ref_clk);
            receiving <= 1'b0;
            repeat (12) @(negedge i_ref_clk);
            chk(32'(abort_req), 32'h0);
            @(posedge i_ref_clk);
            sys_err <= 1'b1;
            @(posedge i_ref_clk);
            sys_err <= 1'b0;
            poll(d[18] ? CMC_MODE_LISTEN : CMC_MODE_RESTRICT);
            // The fallback mode must stay, not drift back to the old request
            repeat (15) @(negedge i_ref_clk);
            chk(32'(mode), 32'(d[18] ? CMC_MODE_LISTEN : CMC_MODE_RESTRICT));
            @(posedge i_ref_clk);
            receiving <= 1'b1;
         end
         wr(4'h8, 32'h0400_0000);
         if (m == 0) begin
            repeat (20) @(negedge i_ref_clk);
            chk(32'(mode == CMC_MODE_CONFIG), 32'h0);
            @(posedge i_ref_clk);
            receiving <= 1'b0;
         end
         poll(CMC_MODE_CONFIG);
      end
      foreach (codes[i]) begin
         wr(4'h8, {4'(codes[i]), 4'h4, 24'h0});
         repeat (12) @(posedge i_ref_clk);
         send_done <= 1'b1;
         @(posedge i_ref_clk);
         send_done <= 1'b0;
         cnt = 0;
         @(negedge i_ref_clk);
         while (hold === 1'b1 && cnt < 5000) begin
            @(negedge i_ref_clk);
            cnt++;
         end
         chk(32'(cnt >= gaps[i] - 2 && cnt <= gaps[i] + 2), 32'h1);
      end
      conclude();
   end
   initial begin
      repeat (40000) @(posedge i_ref_clk);
      fails++;
      conclude();
   end
endmodule
bind cmc_top cmc_top_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
   .i_reg_be(i_reg_be), .o_reg_rdata(o_reg_rdata), .i_sending(i_sending),
   .i_receiving(i_receiving), .i_aborts_done(i_aborts_done),
   .i_error_passive(i_error_passive), .i_msg_esi(i_msg_esi), .i_msg_brs(i_msg_brs),
   .o_mode(o_mode), .o_abort_req(o_abort_req), .o_queue_on(o_queue_on),
   .o_log_on(o_log_on), .o_esi_tx(o_esi_tx), .o_brs_tx(o_brs_tx),
   .o_data_filter_bits(o_data_filter_bits), .o_wake(o_wake));
